// ---- tb/debug_probe_port_options_tb.sv ----
`timescale 1ns/1ns
module debug_probe_port_options_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sclk, sdo, soe, sdi, tdi, tdo, trs, trs_oe, srs, srs_oe;
   logic req, grant, tool;
   logic req_seen = 1'b0;
   logic sclk_q = 1'b0;
   logic [63:0] rsh;
   logic [31:0] fsh, jsh;
   int n_mismatch, checked, rises0;
   int rises = 0;
   dpp_probe_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .swclk_tck_o(sclk), .swdio_tms_o(sdo), .swdio_tms_oe(soe),
      .swdio_tms_i(sdi), .tdi_o(tdi), .tdo_i(tdo), .test_reset_n_o(trs),
      .test_reset_n_oe(trs_oe), .system_reset_n_o(srs),
      .system_reset_n_oe(srs_oe), .share_req_o(req),
      .share_grant_i(grant), .tool_detect_i(tool));
   dpp_target_model u_tgt (.pclk(pclk), .presetn(presetn), .swclk(sclk),
      .host_o(sdo), .host_oe(soe), .line(sdi), .tdo(tdo));
   // watch request line; sample the pins as the target would at each edge
   always @(posedge pclk) begin
      sclk_q <= sclk;
      if (req === 1'b1) req_seen <= 1'b1;
      if (sclk === 1'b1 && sclk_q === 1'b0) begin
         rises <= rises + 1;
         rsh <= {sdo, rsh[63:1]};
         jsh <= {tdi, jsh[31:1]};
      end
      if (sclk === 1'b0 && sclk_q === 1'b1) fsh <= {sdo, fsh[31:1]};
   end
   task automatic close_out();
      if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk({31'h0, pslverr}, {31'h0, a > 8'h20});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // poll busy; frames take about 370 cycles, the watchdog bounds the wait
   task automatic wait_idle();
      do begin
         apb(1'b0, 8'h10, 32'h0);
      end while (rd[0] !== 1'b0);
   endtask
   task automatic rst_cmd(input logic [31:0] ctrl, input logic [2:0] op);
      apb(1'b1, 8'h00, ctrl);
      apb(1'b1, 8'h04, {29'h0, op});
      repeat (4) @(posedge pclk);
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #400000;
      n_mismatch++;
      close_out();
   end
   initial begin
      {psel, penable, pwrite, grant, tool} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_mismatch = 0;
      checked = 0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h00, 32'h0000_0005);
      repeat (2) @(posedge pclk);
      chk({sclk, sdo, soe}, 3'b001);
      apb(1'b1, 8'h00, 32'h0000_000d);
      repeat (2) @(posedge pclk);
      chk({sclk, sdo, soe}, 3'b011);
      apb(1'b1, 8'h04, 32'h0000_0004);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
      // swd write with sharing off
      apb(1'b1, 8'h08, 32'ha5c3_0f96);
      apb(1'b1, 8'h04, 32'h0000_0101);
      wait_idle();
      chk({29'h0, rd[3:1]}, 32'h1);
      chk({31'h0, req_seen}, 32'h0);
      // sharing on: traffic held until grant
      apb(1'b1, 8'h00, 32'h0000_0085);
      rises0 = rises;
      apb(1'b1, 8'h04, 32'h0000_0101);
      repeat (40) @(posedge pclk);
      chk({31'h0, req}, 32'h1);
      chk(rises - rises0, 0);
      grant <= 1'b1;
      wait_idle();
      chk({29'h0, rd[3:1]}, 32'h1);
      grant <= 1'b0;
      rst_cmd(32'h0000_0200, 3'd5);
      chk({29'h0, srs_oe, trs, trs_oe}, 32'h2);
      rst_cmd(32'h0000_0000, 3'd5);
      chk({30'h0, srs_oe, srs}, 32'h2);
      rst_cmd(32'h0000_0000, 3'd6);
      chk({31'h0, srs_oe}, 32'h0);
      rst_cmd(32'h0000_0020, 3'd5);
      chk({30'h0, srs_oe, trs}, 32'h3);
      rst_cmd(32'h0000_0000, 3'd6);
      rst_cmd(32'h0000_0060, 3'd5);
      chk({30'h0, trs, trs_oe}, 32'h3);
      rst_cmd(32'h0000_0040, 3'd6);
      rst_cmd(32'h0000_0040, 3'd5);
      chk({30'h0, trs, trs_oe}, 32'h1);
      apb(1'b1, 8'h00, 32'h0040_0000);
      apb(1'b1, 8'h1c, 32'h8000_1000);
      apb(1'b1, 8'h20, 32'h8000_1000);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, rd[8]}, 32'h1);
      apb(1'b1, 8'h20, 32'h8000_2000);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, rd[8]}, 32'h0);
      // switch sequence, falling-edge then rising-edge bit changes
      apb(1'b1, 8'h08, 32'h0000_00b4);
      apb(1'b1, 8'h04, 32'h0000_0802);
      wait_idle();
      chk({24'h0, rsh[63:56]}, 32'hb4);
      apb(1'b1, 8'h00, 32'h0000_0010);
      apb(1'b1, 8'h04, 32'h0000_0802);
      wait_idle();
      chk({24'h0, fsh[31:24]}, 32'hb4);
      apb(1'b1, 8'h00, 32'h0000_0000);
      // jtag shift: tdi carries the word, tms high on the last bit
      apb(1'b1, 8'h08, 32'h0000_0005);
      apb(1'b1, 8'h04, 32'h0000_0403);
      wait_idle();
      chk({28'h0, jsh[31:28]}, 32'h5);
      chk({28'h0, rsh[63:60]}, 32'h8);
      apb(1'b1, 8'h04, 32'h0000_0001);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
      // compact jtag star address, then idle drive per keeper flag
      apb(1'b1, 8'h00, 32'h000a_0002);
      apb(1'b1, 8'h04, 32'h0000_0004);
      wait_idle();
      chk({28'h0, rsh[63:60]}, 32'ha);
      chk({31'h0, soe}, 32'h0);
      apb(1'b1, 8'h00, 32'h000a_0802);
      repeat (2) @(posedge pclk);
      chk({31'h0, soe}, 32'h1);
      // automatic sharing follows the tool detect seen at connect
      tool <= 1'b1;
      apb(1'b1, 8'h00, 32'h0000_0100);
      apb(1'b1, 8'h04, 32'h0000_0007);
      apb(1'b0, 8'h10, 32'h0);
      chk({30'h0, rd[7:6]}, 32'h3);
      tool <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b1, 8'h04, 32'h0000_0007);
      apb(1'b0, 8'h10, 32'h0);
      chk({30'h0, rd[7:6]}, 32'h0);
      // serial select carrying the second port's address
      apb(1'b1, 8'h00, 32'h0020_0005);
      apb(1'b1, 8'h18, 32'h3c5a_0001);
      apb(1'b1, 8'h04, 32'h0000_0084);
      wait_idle();
      chk(rsh[62:31], 32'h3c5a_0001);
      close_out();
   end
endmodule

// ---- tb/dpp_target_model.sv ----
`timescale 1ns/1ns
module dpp_target_model (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic swclk, // link clock from probe
   input wire logic host_o, // probe data level
   input wire logic host_oe, // probe drive enable
   output logic line, // resolved data wire
   output logic tdo // test data back
);
   logic clk_q;
   logic tgt_o;
   logic tgt_oe;
   logic pat;
   logic [5:0] rises;
   logic [4:0] quiet;
   // undriven wire churns so a stale value never reads as valid
   assign line = host_oe ? host_o : (tgt_oe ? tgt_o : pat);
   assign tdo = pat;
   // responder: count link rises, send ack ok lsb first after turnaround
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_q <= 1'b0;
         rises <= 6'h00;
         quiet <= 5'h00;
         tgt_o <= 1'b0;
         tgt_oe <= 1'b0;
         pat <= 1'b0;
      end else begin
         pat <= ~pat;
         clk_q <= swclk;
         quiet <= swclk ? 5'h00 : (quiet == 5'h1f ? quiet : quiet + 5'h01);
         if (quiet == 5'h1f) rises <= 6'h00; // frame over once clock stops
         if (swclk && !clk_q) rises <= rises + 6'h01;
         if (!swclk && clk_q) begin
            tgt_oe <= (rises >= 6'd9) && (rises <= 6'd11);
            tgt_o <= (rises == 6'd9);
         end
      end
   end
endmodule

// ---- verilog/dpp_clkgen.sv ----
`timescale 1ns/1ns
`include "dpp_consts.svh"
module dpp_clkgen #(
   parameter int HALF = `DPP_HALF_CYC
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   dpp_tick_if.gen tk // tick carrier
);
   logic [7:0] cnt_r, cnt_nxt;
   logic ph_r, ph_nxt, rise_r, rise_nxt, fall_r, fall_nxt;

   // half-period divider; phase restarts low whenever run drops
   always_comb begin
      cnt_nxt = 8'h00;
      ph_nxt = 1'b0;
      rise_nxt = 1'b0;
      fall_nxt = 1'b0;
      if (tk.run) begin
         ph_nxt = ph_r;
         if (cnt_r == 8'(HALF - 1)) begin
            ph_nxt = ~ph_r;
            rise_nxt = ~ph_r;
            fall_nxt = ph_r;
         end else begin
            cnt_nxt = cnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 8'h00;
         ph_r <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ph_r <= ph_nxt;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
      end
   end

   assign tk.rise = rise_r;
   assign tk.fall = fall_r;
endmodule

// ---- verilog/dpp_consts.svh ----
`ifndef DPP_CONSTS_SVH
`define DPP_CONSTS_SVH
// register byte offsets
`define DPP_A_CTRL 8'h00
`define DPP_A_CMD 8'h04
`define DPP_A_WDATA 8'h08
`define DPP_A_RDATA 8'h0c
`define DPP_A_STAT 8'h10
`define DPP_A_TSEL1 8'h14
`define DPP_A_TSEL2 8'h18
`define DPP_A_RBASE0 8'h1c
`define DPP_A_RBASE1 8'h20
// control register fields
`define DPP_C_TYPE 1:0
`define DPP_C_SWE 2
`define DPP_C_IDLEH 3
`define DPP_C_RISE 4
`define DPP_C_POLH 5
`define DPP_C_REMAP 6
`define DPP_C_SHARE 8:7
`define DPP_C_SEC 9
`define DPP_C_FLAGS 14:10
`define DPP_C_NOKEEP 11
`define DPP_C_TCA 19:16
`define DPP_C_SEL1V 20
`define DPP_C_SEL2V 21
`define DPP_C_SAMECHIP 22
`define DPP_CTRL_RST 32'h0000_0000
`define DPP_CTRL_MASK 32'h007f_7fff
// command register fields
`define DPP_K_OP 2:0
`define DPP_K_APNDP 3
`define DPP_K_RNW 4
`define DPP_K_ADDR 6:5
`define DPP_K_SEL2 7
`define DPP_K_CNT 13:8
// serial wire framing
`define DPP_SWD_LAST 6'd45
`define DPP_ACK_BIT 6'd12
`define DPP_ACK_OK 3'h1
`define DPP_TSEL_REQ 8'h99
// link timing
`define DPP_CLK_NS 20
`define DPP_LINK_NS 160
`define DPP_HALF_CYC (`DPP_LINK_NS / (2 * `DPP_CLK_NS))
`endif

// ---- verilog/dpp_pkg.sv ----
package dpp_pkg;
   typedef enum logic [1:0] {PT_JTAG, PT_SWD, PT_CJTAG, PT_CJTAG_SWD}
      dpp_port_t;
   typedef enum logic [2:0] {OP_NONE, OP_SWD, OP_SWITCH, OP_JTAG, OP_TSEL,
      OP_RST_ON, OP_RST_OFF, OP_CONNECT} dpp_op_t;
   typedef enum logic [1:0] {SH_OFF, SH_ON, SH_AUTO} dpp_share_t;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} dpp_state_t;
endpackage

// ---- verilog/dpp_probe_port.sv ----
`timescale 1ns/1ns
`include "dpp_consts.svh"
module dpp_probe_port (
   input wire logic pclk, // system clock, 50 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   output logic swclk_tck_o, // link clock
   output logic swdio_tms_o, // data / mode pin level
   output logic swdio_tms_oe, // data / mode pin drive enable
   input wire logic swdio_tms_i, // data / mode pin sensed
   output logic tdi_o, // test data to target
   input wire logic tdo_i, // test data from target
   output logic test_reset_n_o, // test reset level
   output logic test_reset_n_oe, // test reset drive enable
   output logic system_reset_n_o, // system reset level, open drain
   output logic system_reset_n_oe, // system reset pull enable
   output logic share_req_o, // port access request
   input wire logic share_grant_i, // port access grant
   input wire logic tool_detect_i // second tool present
);
   logic [31:0] ctrl_r, ctrl_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [31:0] tsel1_r, tsel1_nxt, tsel2_r, tsel2_nxt;
   logic [31:0] rbase0_r, rbase0_nxt, rbase1_r, rbase1_nxt;
   logic [31:0] prdata_nxt, rd_mux, stat_w, sel_w;
   logic pready_nxt, pslverr_nxt, hit, shared_r, shared_nxt;
   logic wr_acc, wr_cmd, swd_m, cj_m, share_eff, sel_v, p_go;
   logic [3:0] sync_q;
   logic dio_s, tdo_s, grant_s, tool_s;
   dpp_pkg::dpp_state_t st_r, st_nxt;
   dpp_pkg::dpp_op_t op_r, op_nxt, op_in;
   logic [5:0] idx_r, idx_nxt, last_r, last_nxt, p_last;
   logic [63:0] out_r, out_nxt, oe_r, oe_nxt, cap_r, cap_nxt, p_out, p_oe;
   logic seen_r, seen_nxt, rst_r, rst_nxt, tool_r, tool_nxt;
   logic [2:0] ack_r, ack_nxt;
   logic perr_r, perr_nxt, req_r, req_nxt, clk_r, clk_nxt;
   logic dio_r, dio_nxt, doe_r, doe_nxt, tdi_r, tdi_nxt;
   logic trst_r, trst_nxt, trst_oe_r, trst_oe_nxt, srst_oe_r, srst_oe_nxt;
   logic jtag_r, rise_m, adv, bad_ack, master, remap, pol_h;

   dpp_tick_if tk ();

   dpp_clkgen #(.HALF(`DPP_HALF_CYC)) u_clkgen (
      .pclk(pclk),
      .presetn(presetn),
      .tk(tk.gen)
   );

   // pins from outside are only read after two stages
   dpp_sync #(.W(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({swdio_tms_i, tdo_i, share_grant_i, tool_detect_i}),
      .q(sync_q)
   );
   assign {dio_s, tdo_s, grant_s, tool_s} = sync_q;

   // mode decode
   assign swd_m = ctrl_r[`DPP_C_SWE] ||
      ctrl_r[`DPP_C_TYPE] == dpp_pkg::PT_SWD ||
      ctrl_r[`DPP_C_TYPE] == dpp_pkg::PT_CJTAG_SWD;
   assign cj_m = ctrl_r[`DPP_C_TYPE] == dpp_pkg::PT_CJTAG ||
      ctrl_r[`DPP_C_TYPE] == dpp_pkg::PT_CJTAG_SWD;
   assign share_eff = ctrl_r[`DPP_C_SHARE] == dpp_pkg::SH_ON ||
      (ctrl_r[`DPP_C_SHARE] == dpp_pkg::SH_AUTO && tool_r);
   assign master = !ctrl_r[`DPP_C_SEC];
   assign remap = ctrl_r[`DPP_C_REMAP];
   assign pol_h = ctrl_r[`DPP_C_POLH] && remap;
   assign wr_acc = psel && penable && pwrite && pready;
   assign wr_cmd = wr_acc && paddr == `DPP_A_CMD;
   assign op_in = dpp_pkg::dpp_op_t'(pwdata[`DPP_K_OP]);
   assign sel_w = pwdata[`DPP_K_SEL2] ? tsel2_r : tsel1_r;
   assign sel_v = pwdata[`DPP_K_SEL2] ? ctrl_r[`DPP_C_SEL2V] :
      ctrl_r[`DPP_C_SEL1V];
   assign jtag_r = op_r == dpp_pkg::OP_JTAG;
   assign tk.run = st_r == dpp_pkg::ST_RUN;
   assign stat_w = {22'h0, rst_r, shared_r, share_eff, tool_r, grant_s,
      perr_r, ack_r, st_r != dpp_pkg::ST_IDLE};

   // register read mux and address decode
   always_comb begin
      hit = 1'b1;
      case (paddr)
         `DPP_A_CTRL: rd_mux = ctrl_r;
         `DPP_A_CMD: rd_mux = {26'h0, idx_r};
         `DPP_A_WDATA: rd_mux = wdata_r;
         `DPP_A_RDATA: rd_mux = rdata_r;
         `DPP_A_STAT: rd_mux = stat_w;
         `DPP_A_TSEL1: rd_mux = tsel1_r;
         `DPP_A_TSEL2: rd_mux = tsel2_r;
         `DPP_A_RBASE0: rd_mux = rbase0_r;
         `DPP_A_RBASE1: rd_mux = rbase1_r;
         default: begin
            rd_mux = 32'h0;
            hit = 1'b0;
         end
      endcase
   end

   // bus slave: answer one cycle after setup, registered data and error
   always_comb begin
      ctrl_nxt = ctrl_r;
      wdata_nxt = wdata_r;
      tsel1_nxt = tsel1_r;
      tsel2_nxt = tsel2_r;
      rbase0_nxt = rbase0_r;
      rbase1_nxt = rbase1_r;
      prdata_nxt = prdata;
      pready_nxt = psel && !penable;
      pslverr_nxt = 1'b0;
      if (psel && !penable) begin
         pslverr_nxt = !hit;
         prdata_nxt = pwrite ? 32'h0 : rd_mux;
      end
      if (wr_acc) begin
         case (paddr)
            `DPP_A_CTRL: ctrl_nxt = pwdata & `DPP_CTRL_MASK;
            `DPP_A_WDATA: wdata_nxt = pwdata;
            `DPP_A_TSEL1: tsel1_nxt = pwdata;
            `DPP_A_TSEL2: tsel2_nxt = pwdata;
            `DPP_A_RBASE0: rbase0_nxt = pwdata;
            `DPP_A_RBASE1: rbase1_nxt = pwdata;
            default: ;
         endcase
      end
      shared_nxt = ctrl_r[`DPP_C_SAMECHIP] && rbase0_r == rbase1_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `DPP_CTRL_RST;
         wdata_r <= 32'h0;
         tsel1_r <= 32'h0;
         tsel2_r <= 32'h0;
         rbase0_r <= 32'h0;
         rbase1_r <= 32'h0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         shared_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         wdata_r <= wdata_nxt;
         tsel1_r <= tsel1_nxt;
         tsel2_r <= tsel2_nxt;
         rbase0_r <= rbase0_nxt;
         rbase1_r <= rbase1_nxt;
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
         shared_r <= shared_nxt;
      end
   end

   // bit plan for a new command, bit 0 goes out first
   always_comb begin
      p_out = 64'h0;
      p_oe = 64'h0;
      p_last = `DPP_SWD_LAST;
      p_go = 1'b0;
      case (op_in)
         dpp_pkg::OP_SWD: begin
            p_out[7:0] = {1'b1, 1'b0, ^pwdata[6:3], pwdata[6:5],
               pwdata[`DPP_K_RNW], pwdata[`DPP_K_APNDP], 1'b1};
            p_oe[7:0] = 8'hff;
            if (!pwdata[`DPP_K_RNW]) begin
               p_out[45:13] = {^wdata_r, wdata_r};
               p_oe[45:13] = 33'h1_ffff_ffff;
            end
            p_go = swd_m;
         end
         dpp_pkg::OP_TSEL: begin
            if (ctrl_r[`DPP_C_TYPE] == dpp_pkg::PT_CJTAG) begin
               p_out[3:0] = ctrl_r[`DPP_C_TCA];
               p_oe[3:0] = 4'hf;
               p_last = 6'd3;
               p_go = 1'b1;
            end else begin
               p_out[7:0] = `DPP_TSEL_REQ;
               p_out[45:13] = {^sel_w, sel_w};
               p_oe[7:0] = 8'hff;
               p_oe[45:13] = 33'h1_ffff_ffff;
               p_go = swd_m && sel_v;
            end
         end
         dpp_pkg::OP_SWITCH, dpp_pkg::OP_JTAG: begin
            p_out[31:0] = wdata_r;
            p_oe = {64{1'b1}};
            p_last = pwdata[`DPP_K_CNT] - 6'd1;
            p_go = pwdata[`DPP_K_CNT] != 6'd0 &&
               (op_in == dpp_pkg::OP_SWITCH || !swd_m);
         end
         default: ;
      endcase
   end

   // rising-edge option only applies to the switch sequence
   assign rise_m = op_r == dpp_pkg::OP_SWITCH && ctrl_r[`DPP_C_RISE];
   assign adv = idx_r != last_r &&
      (rise_m ? (tk.rise && seen_r) : tk.fall);
   assign bad_ack = op_r == dpp_pkg::OP_SWD && idx_r == `DPP_ACK_BIT &&
      cap_r[11:9] != `DPP_ACK_OK;

   // link engine: sharing handshake, bit shifting, reset lines
   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      last_nxt = last_r;
      out_nxt = out_r;
      oe_nxt = oe_r;
      cap_nxt = cap_r;
      seen_nxt = seen_r;
      rst_nxt = rst_r;
      tool_nxt = tool_r;
      ack_nxt = ack_r;
      perr_nxt = perr_r;
      rdata_nxt = rdata_r;
      req_nxt = req_r;
      clk_nxt = clk_r;
      dio_nxt = dio_r;
      doe_nxt = doe_r;
      tdi_nxt = tdi_r;
      case (st_r)
         dpp_pkg::ST_IDLE: begin
            clk_nxt = 1'b0;
            dio_nxt = swd_m && ctrl_r[`DPP_C_IDLEH];
            doe_nxt = cj_m ? ctrl_r[`DPP_C_NOKEEP] : 1'b1;
            if (wr_cmd) begin
               case (op_in)
                  dpp_pkg::OP_RST_ON: rst_nxt = 1'b1;
                  dpp_pkg::OP_RST_OFF: rst_nxt = 1'b0;
                  dpp_pkg::OP_CONNECT: tool_nxt = tool_s;
                  default: ;
               endcase
               if (p_go) begin
                  op_nxt = op_in;
                  idx_nxt = 6'd0;
                  last_nxt = p_last;
                  out_nxt = p_out;
                  oe_nxt = p_oe;
                  cap_nxt = 64'h0;
                  seen_nxt = 1'b0;
                  req_nxt = share_eff;
                  st_nxt = share_eff ? dpp_pkg::ST_WAIT :
                     dpp_pkg::ST_RUN;
               end
            end
         end
         dpp_pkg::ST_WAIT: begin
            if (grant_s) begin
               st_nxt = dpp_pkg::ST_RUN;
            end
         end
         dpp_pkg::ST_RUN: begin
            if (tk.rise) begin
               clk_nxt = 1'b1;
               seen_nxt = 1'b1;
               if (jtag_r || !oe_r[idx_r]) begin
                  cap_nxt[idx_r] = jtag_r ? tdo_s : dio_s;
               end
            end
            if (tk.fall) begin
               clk_nxt = 1'b0;
            end
            if (tk.fall && (idx_r == last_r || bad_ack)) begin
               st_nxt = dpp_pkg::ST_IDLE;
               req_nxt = 1'b0;
               ack_nxt = cap_r[11:9];
               rdata_nxt = jtag_r ? cap_r[31:0] : cap_r[43:12];
               perr_nxt = op_r == dpp_pkg::OP_SWD && out_r[2] &&
                  !bad_ack && ^cap_r[44:12];
            end else if (adv) begin
               idx_nxt = idx_r + 6'd1;
            end
         end
         default: st_nxt = dpp_pkg::ST_IDLE;
      endcase
      // drive the new bit when a run starts or the index moves
      if (st_nxt == dpp_pkg::ST_RUN &&
         (st_r != dpp_pkg::ST_RUN || idx_nxt != idx_r)) begin
         dio_nxt = op_nxt == dpp_pkg::OP_JTAG ? idx_nxt == last_nxt :
            out_nxt[idx_nxt];
         doe_nxt = op_nxt == dpp_pkg::OP_JTAG || oe_nxt[idx_nxt];
         tdi_nxt = out_nxt[idx_nxt];
      end
      // reset lines, secondary never drives them
      trst_oe_nxt = master;
      trst_nxt = remap ? (pol_h ? rst_r : !rst_r) : 1'b1;
      srst_oe_nxt = master && !remap && rst_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= dpp_pkg::ST_IDLE;
         op_r <= dpp_pkg::OP_NONE;
         idx_r <= 6'd0;
         last_r <= 6'd0;
         out_r <= 64'h0;
         oe_r <= 64'h0;
         cap_r <= 64'h0;
         seen_r <= 1'b0;
         rst_r <= 1'b0;
         tool_r <= 1'b0;
         ack_r <= 3'h0;
         perr_r <= 1'b0;
         rdata_r <= 32'h0;
         req_r <= 1'b0;
         clk_r <= 1'b0;
         dio_r <= 1'b0;
         doe_r <= 1'b1;
         tdi_r <= 1'b0;
         trst_r <= 1'b1;
         trst_oe_r <= 1'b1;
         srst_oe_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         last_r <= last_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         cap_r <= cap_nxt;
         seen_r <= seen_nxt;
         rst_r <= rst_nxt;
         tool_r <= tool_nxt;
         ack_r <= ack_nxt;
         perr_r <= perr_nxt;
         rdata_r <= rdata_nxt;
         req_r <= req_nxt;
         clk_r <= clk_nxt;
         dio_r <= dio_nxt;
         doe_r <= doe_nxt;
         tdi_r <= tdi_nxt;
         trst_r <= trst_nxt;
         trst_oe_r <= trst_oe_nxt;
         srst_oe_r <= srst_oe_nxt;
      end
   end

   // every pin straight from a flop, except system_reset_n_o which is tied low
   assign swclk_tck_o = clk_r;
   assign swdio_tms_o = dio_r;
   assign swdio_tms_oe = doe_r;
   assign tdi_o = tdi_r;
   assign test_reset_n_o = trst_r;
   assign test_reset_n_oe = trst_oe_r;
   assign system_reset_n_o = 1'b0;
   assign system_reset_n_oe = srst_oe_r;
   assign share_req_o = req_r;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   idle_clk_low_a: assert property (
      st_r == dpp_pkg::ST_IDLE ##1 st_r == dpp_pkg::ST_IDLE |-> !clk_r)
      else $error("link clock not low while idle");
   idle_data_lvl_a: assert property (
      (st_r == dpp_pkg::ST_IDLE && swd_m && $stable(ctrl_r))[*2]
      |-> dio_r == ctrl_r[`DPP_C_IDLEH])
      else $error("idle data level wrong");
   share_hold_a: assert property (
      st_r == dpp_pkg::ST_WAIT && !grant_s
      |=> st_r != dpp_pkg::ST_RUN && req_r && !clk_r)
      else $error("traffic before grant");
   share_off_a: assert property (
      st_r == dpp_pkg::ST_IDLE && wr_cmd && p_go && !share_eff
      |=> st_r == dpp_pkg::ST_RUN && !req_r)
      else $error("request raised with sharing off");
   switch_edge_a: assert property (
      st_r == dpp_pkg::ST_RUN && $past(st_r) == dpp_pkg::ST_RUN &&
      $changed(dio_r) |-> clk_r == rise_m)
      else $error("data changed on wrong clock edge");
   secondary_rst_a: assert property (
      (ctrl_r[`DPP_C_SEC])[*2] |-> !trst_oe_r && !srst_oe_r)
      else $error("secondary drives reset");
   polarity_gate_a: assert property (
      (!remap)[*2] |-> trst_r)
      else $error("polarity acted without remap");
   remap_drive_a: assert property (
      (remap && master && rst_r && $stable(ctrl_r))[*2]
      |-> trst_r == pol_h && !srst_oe_r)
      else $error("remapped reset not on test reset");
   tsel_skip_a: assert property (
      st_r == dpp_pkg::ST_IDLE && wr_cmd && op_in == dpp_pkg::OP_TSEL &&
      swd_m && ctrl_r[`DPP_C_TYPE] != dpp_pkg::PT_CJTAG && !sel_v
      |=> st_r == dpp_pkg::ST_IDLE)
      else $error("select sent with no address set");
   swd_read_c: cover property (
      st_r == dpp_pkg::ST_RUN && op_r == dpp_pkg::OP_SWD && out_r[2]
      ##1 st_r == dpp_pkg::ST_IDLE);
   switch_rise_c: cover property (
      st_r == dpp_pkg::ST_RUN && rise_m ##1 st_r == dpp_pkg::ST_IDLE);
   share_wait_c: cover property (
      st_r == dpp_pkg::ST_WAIT ##1 st_r == dpp_pkg::ST_RUN);
   tsel_c: cover property (
      st_r == dpp_pkg::ST_RUN && op_r == dpp_pkg::OP_TSEL);
endmodule

// ---- verilog/dpp_sync.sv ----
`timescale 1ns/1ns
module dpp_sync #(
   parameter int W = 1
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [W-1:0] d, // asynchronous inputs
   output logic [W-1:0] q // synchronised outputs
);
   logic [W-1:0] meta_r;

   // two stages; only the second stage is ever read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ---- verilog/dpp_tick_if.sv ----
`timescale 1ns/1ns
// link bit-clock ticks between divider and engine
interface dpp_tick_if;
   logic run;
   logic rise;
   logic fall;
   modport gen (input run, output rise, output fall);
   modport eng (output run, input rise, input fall);
endinterface
